// ---- common/acq_consts.svh ----
// Purpose: Named constants for the run sequencer and transfer engine
// Assumes: Included by bare name; definitions only
// Notes:   Printed register offsets are indices; byte address is index * 4
`ifndef ACQ_CONSTS_SVH
`define ACQ_CONSTS_SVH
// ****************************************
// Register indices and local byte addresses
// ****************************************
`define IDX_CMD        20'h0_0064
`define IDX_STATUS     20'h0_006e
`define IDX_MEMTEST    20'h3_0ffc
`define ADR_MODE       20'h0_0000
`define ADR_PRE        20'h0_0004
`define ADR_POST       20'h0_0008
`define ADR_MEMSIZE    20'h0_000c
`define ADR_TIMEOUT    20'h0_0010
`define ADR_BTYPE      20'h0_0014
`define ADR_BDIR       20'h0_0018
`define ADR_NOTIFY     20'h0_001c
`define ADR_OFFSET     20'h0_0020
`define ADR_LENGTH     20'h0_0024
`define ADR_BUFCTL     20'h0_0028
// ****************************************
// Command, status and field bit positions
// ****************************************
`define CMD_RUN_BEGIN  2
`define CMD_TRIG_ARM   3
`define CMD_XF_BEGIN   16
`define CMD_XF_WAIT    17
`define CMD_XF_ABORT   18
`define ST_PRE         0
`define ST_TRIG        1
`define ST_DONE        2
`define ST_BLOCK       8
`define ST_END         9
`define ST_OVR         10
`define ST_ERR         11
`define MODE_GEN       0
`define MODE_FIFO      1
`define BUFCTL_DEFINE  0
`define BUFCTL_INVAL   1
// ****************************************
// Codes, response values and timing
// ****************************************
`define BUF_SAMPLE     32'h0000_03e8
`define BUF_SLOW       32'h0000_07d0
`define BUF_STAMP      32'h0000_0bb8
`define DIR_H2B        32'h0000_0000
`define DIR_B2H        32'h0000_0001
`define BEAT_BYTES     32'h0000_0004
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`define MS_NS          1000000
`define CLK_PERIOD_NS  10
`endif

// ---- common/acq_pkg.sv ----
// Purpose: Types shared by the run and transfer control block
// Assumes: Used with package-qualified names only
// Notes:   Whole block state is one packed struct
package acq_pkg;
  // Run sequencer states
  typedef enum logic [3:0] {
    R_IDLE = 4'h1,
    R_PRE  = 4'h2,
    R_TRIG = 4'h4,
    R_POST = 4'h8
  } run_state_type;
  // Transfer engine states
  typedef enum logic [2:0] {
    X_IDLE = 3'h1,
    X_HOLD = 3'h2,
    X_RUN  = 3'h4
  } xfer_state_type;
  // Complete register state
  typedef struct packed {
    run_state_type  rstate;
    xfer_state_type xstate;
    logic [6:0]     flags;   // pre, trig, done, block, end, ovr, err
    logic           trig_en;
    logic [31:0]    cnt;
    logic [1:0]     mode;
    logic [31:0]    pre_cnt;
    logic [31:0]    post_cnt;
    logic [31:0]    memsize;
    logic [31:0]    tmo_ms;
    logic [31:0]    s_type;
    logic [31:0]    s_dir;
    logic [31:0]    s_notify;
    logic [31:0]    s_offs;
    logic [31:0]    s_len;
    logic [1:0]     b_idx;
    logic           b_dir;
    logic [31:0]    notify;
    logic [31:0]    offs;
    logic [31:0]    len;
    logic [2:0]     valid;
    logic           memtest;
    logic [31:0]    addr;
    logic [31:0]    moved;
    logic [31:0]    blk;
    logic           wait_busy;
    logic [31:0]    tmo_cnt;
    logic [31:0]    ms_cnt;
    logic           notify_evt;
    logic           run_active;
    logic           xfer_active;
    logic           aw_got;
    logic           w_got;
    logic [19:0]    awaddr;
    logic [31:0]    wdata;
    logic [3:0]     wstrb;
    logic           awready;
    logic           wready;
    logic           bvalid;
    logic [1:0]     bresp;
    logic           arready;
    logic           rvalid;
    logic [31:0]    rdata;
    logic [1:0]     rresp;
  } state_type;
endpackage

// ---- rtl/acq_run_and_transfer_control.sv ----
// Purpose: Run sequencer and host transfer engine behind AXI4-Lite
// Assumes: Samples, triggers and transfer beats arrive synchronous to aclk
// Notes:   Each transfer beat moves four bytes at xfer_addr
`include "acq_consts.svh"
module acq_run_and_transfer_control #(
  parameter int MS_CYCLES = `MS_NS / `CLK_PERIOD_NS  // Clock cycles per millisecond
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [19:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // AXI4-Lite write response
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // AXI4-Lite read
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [19:0] araddr,
  input  wire logic [2:0]  arprot,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // Acquisition front end
  input  wire logic        sample_tick,
  input  wire logic        trigger_in,
  // Memory mover
  input  wire logic        xfer_beat,
  input  wire logic        xfer_fail,
  input  wire logic        fifo_flow_err,
  // Status outputs
  output logic             run_active,
  output logic             trig_armed,
  output logic             xfer_active,
  output logic             xfer_dir,
  output logic [31:0]      xfer_addr,
  output logic             wait_busy,
  output logic             notify_evt,
  output logic             memory_test_enable
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Byte address of a printed register index
  function automatic logic [19:0] idx_addr(input logic [19:0] idx);
    idx_addr = {idx[17:0], 2'b00};
  endfunction

  // Buffer type code to slot index, 3 marks an unknown code
  function automatic logic [1:0] type_idx(input logic [31:0] code);
    if (code == `BUF_SAMPLE) begin
      type_idx = 2'd0;
    end else if (code == `BUF_SLOW) begin
      type_idx = 2'd1;
    end else if (code == `BUF_STAMP) begin
      type_idx = 2'd2;
    end else begin
      type_idx = 2'd3;
    end
  endfunction

  // Byte-lane merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  acq_pkg::state_type q;    // Registered state
  acq_pkg::state_type n;    // Next state

  // Scratch values of the combinational process
  logic [31:0] cmd;         // Command word of this cycle
  logic [31:0] wv;          // Merged write value
  logic        bad;         // Definition refused
  logic [1:0]  ti;          // Staged type index
  logic [31:0] status;      // Status word

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    n          = q;
    cmd        = '0;
    wv         = '0;
    bad        = 1'b0;
    ti         = type_idx(q.s_type);
    n.notify_evt = 1'b0;
    // Status word, reading it changes nothing
    status = '0;
    status[`ST_PRE]   = q.flags[0];
    status[`ST_TRIG]  = q.flags[1];
    status[`ST_DONE]  = q.flags[2];
    status[`ST_BLOCK] = q.flags[3];
    status[`ST_END]   = q.flags[4];
    status[`ST_OVR]   = q.flags[5];
    status[`ST_ERR]   = q.flags[6];

    // Capture write address and data in either order
    if (awvalid && q.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = awaddr;
    end
    if (wvalid && q.wready) begin
      n.w_got = 1'b1;
      n.wdata = wdata;
      n.wstrb = wstrb;
    end
    // Response retires, channels reopen
    if (q.bvalid && bready) begin
      n.bvalid = 1'b0;
    end

    // ****************************************
    // Run sequencer
    // ****************************************
    case (q.rstate)
      // Pretrigger fill, triggers ignored meanwhile
      acq_pkg::R_PRE: begin
        if (sample_tick) begin
          n.cnt = q.cnt + 32'd1;
          if (n.cnt >= q.pre_cnt) begin
            n.flags[0] = 1'b1;
            n.cnt      = '0;
            n.rstate   = acq_pkg::R_TRIG;
          end
        end
      end
      // Armed, trigger counts only when enabled
      acq_pkg::R_TRIG: begin
        if (q.trig_en && trigger_in) begin
          n.flags[1] = 1'b1;
          n.cnt      = '0;
          n.rstate   = acq_pkg::R_POST;
        end
      end
      // Post-trigger capture or replay
      acq_pkg::R_POST: begin
        if (sample_tick) begin
          n.cnt = q.cnt + 32'd1;
          if (n.cnt >= q.post_cnt) begin
            n.flags[2] = 1'b1;
            n.trig_en  = 1'b0;
            n.rstate   = acq_pkg::R_IDLE;
          end
        end
      end
      default: begin
      end
    endcase

    // ****************************************
    // Transfer engine
    // ****************************************
    case (q.xstate)
      // Held back until the first trigger
      acq_pkg::X_HOLD: begin
        if (q.flags[1]) begin
          n.xstate = acq_pkg::X_RUN;
        end
      end
      // Each beat moves one word
      acq_pkg::X_RUN: begin
        if (xfer_beat) begin
          n.addr  = q.addr + `BEAT_BYTES;
          n.moved = q.moved + `BEAT_BYTES;
          n.blk   = q.blk + `BEAT_BYTES;
          if (q.notify != '0 && n.blk >= q.notify) begin
            n.flags[3]   = 1'b1;
            n.notify_evt = 1'b1;
            n.blk        = '0;
          end
          if (n.moved >= q.len) begin
            n.valid[q.b_idx] = 1'b0;
            n.xstate         = acq_pkg::X_IDLE;
            if (q.notify == '0) begin
              n.flags[4]   = 1'b1;
              n.notify_evt = 1'b1;
            end
          end
        end
      end
      default: begin
      end
    endcase
    // Error inputs only count while data moves
    if (fifo_flow_err && q.xstate == acq_pkg::X_RUN) begin
      n.flags[5] = 1'b1;
    end
    if (xfer_fail && q.xstate == acq_pkg::X_RUN) begin
      n.flags[6] = 1'b1;
    end

    // ****************************************
    // Register writes
    // ****************************************
    if (n.aw_got && n.w_got && !q.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = `RESP_OKAY;
      if (n.awaddr == idx_addr(`IDX_CMD)) begin
        cmd = merge('0, n.wdata, n.wstrb);
      end else if (n.awaddr == idx_addr(`IDX_MEMTEST)) begin
        wv        = merge({31'd0, q.memtest}, n.wdata, n.wstrb);
        n.memtest = wv[0];
      end else if (n.awaddr == `ADR_MODE) begin
        wv     = merge({30'd0, q.mode}, n.wdata, n.wstrb);
        n.mode = wv[1:0];
      end else if (n.awaddr == `ADR_PRE) begin
        n.pre_cnt = merge(q.pre_cnt, n.wdata, n.wstrb);
      end else if (n.awaddr == `ADR_POST) begin
        n.post_cnt = merge(q.post_cnt, n.wdata, n.wstrb);
      end else if (n.awaddr == `ADR_MEMSIZE) begin
        n.memsize = merge(q.memsize, n.wdata, n.wstrb);
      end else if (n.awaddr == `ADR_TIMEOUT) begin
        n.tmo_ms = merge(q.tmo_ms, n.wdata, n.wstrb);
      end else if (n.awaddr == `ADR_BTYPE) begin
        n.s_type = merge(q.s_type, n.wdata, n.wstrb);
      end else if (n.awaddr == `ADR_BDIR) begin
        n.s_dir = merge(q.s_dir, n.wdata, n.wstrb);
      end else if (n.awaddr == `ADR_NOTIFY) begin
        n.s_notify = merge(q.s_notify, n.wdata, n.wstrb);
      end else if (n.awaddr == `ADR_OFFSET) begin
        n.s_offs = merge(q.s_offs, n.wdata, n.wstrb);
      end else if (n.awaddr == `ADR_LENGTH) begin
        n.s_len = merge(q.s_len, n.wdata, n.wstrb);
      end else if (n.awaddr == `ADR_BUFCTL) begin
        wv = merge('0, n.wdata, n.wstrb);
        // Any buffer action on the running type stops it first
        if ((wv[`BUFCTL_DEFINE] || wv[`BUFCTL_INVAL]) && ti == q.b_idx) begin
          n.xstate = acq_pkg::X_IDLE;
        end
        if (wv[`BUFCTL_INVAL] && ti != 2'd3) begin
          n.valid[ti] = 1'b0;
        end else if (wv[`BUFCTL_DEFINE]) begin
          // Unknown type, bad direction code, direction against the mode outside memory test or, outside FIFO mode, oversize length is refused
          bad = (ti == 2'd3);
          bad = bad || (q.s_dir != `DIR_H2B && q.s_dir != `DIR_B2H);
          if (!q.memtest) begin
            bad = bad || (q.mode[`MODE_GEN] ? q.s_dir == `DIR_B2H
                                            : q.s_dir == `DIR_H2B);
          end
          bad = bad || (!q.mode[`MODE_FIFO] && q.s_len > q.memsize);
          if (bad) begin
            n.flags[6] = 1'b1;
          end else begin
            // One slot only: the new type replaces whatever it held
            n.valid     = 3'b000;
            n.valid[ti] = 1'b1;
            n.b_idx     = ti;
            n.b_dir     = q.s_dir[0];
            n.notify    = q.s_notify;
            n.offs      = q.s_offs;
            n.len       = q.s_len;
          end
        end
      end else begin
        n.bresp = `RESP_SLVERR;          // Unmapped or read-only target
      end
    end

    // ****************************************
    // Commands, bits of one write act together, except that abort overrides begin
    // ****************************************
    if (!q.memtest) begin
      if (cmd[`CMD_RUN_BEGIN]) begin
        n.flags[2:0] = 3'b000;
        n.cnt        = '0;
        n.trig_en    = cmd[`CMD_TRIG_ARM];
        n.rstate     = q.mode[`MODE_GEN] ? acq_pkg::R_TRIG : acq_pkg::R_PRE;
      end else if (cmd[`CMD_TRIG_ARM] && q.rstate != acq_pkg::R_IDLE) begin
        n.trig_en = 1'b1;
      end
    end
    if (cmd[`CMD_XF_ABORT]) begin
      if (q.xstate != acq_pkg::X_IDLE) begin
        n.valid[q.b_idx] = 1'b0;
      end
      n.xstate = acq_pkg::X_IDLE;
    end else if (cmd[`CMD_XF_BEGIN] && q.xstate == acq_pkg::X_IDLE) begin
      if (q.valid[q.b_idx]) begin
        n.flags[4:3] = 2'b00;
        n.addr  = q.mode[`MODE_FIFO] ? '0 : q.offs;
        n.moved = '0;
        n.blk   = '0;
        // Acquisition without a trigger yet holds the transfer
        if (!q.memtest && !q.mode[`MODE_GEN] && !n.flags[1]) begin
          n.xstate = acq_pkg::X_HOLD;
        end else begin
          n.xstate = acq_pkg::X_RUN;
        end
      end else begin
        n.flags[6] = 1'b1;
      end
    end

    // ****************************************
    // Wait for block, end or timeout
    // ****************************************
    if (cmd[`CMD_XF_WAIT]) begin
      n.wait_busy = 1'b1;
      n.tmo_cnt   = '0;
      n.ms_cnt    = '0;
    end else if (q.wait_busy) begin
      if (q.ms_cnt >= 32'(MS_CYCLES - 1)) begin
        n.ms_cnt  = '0;
        n.tmo_cnt = q.tmo_cnt + 32'd1;
      end else begin
        n.ms_cnt = q.ms_cnt + 32'd1;
      end
    end
    // A block already waiting ends the wait at once
    if (n.wait_busy && (n.flags[3] || n.flags[4] || n.xstate == acq_pkg::X_IDLE ||
        (q.tmo_ms != '0 && n.tmo_cnt >= q.tmo_ms))) begin
      n.wait_busy = 1'b0;
    end

    // ****************************************
    // Register reads
    // ****************************************
    if (arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = `RESP_OKAY;
      n.rdata  = '0;
      if (araddr == idx_addr(`IDX_STATUS)) begin
        n.rdata = status;
      end else if (araddr == idx_addr(`IDX_CMD)) begin
        n.rdata = '0;                    // Write-only, reads zero
      end else if (araddr == idx_addr(`IDX_MEMTEST)) begin
        n.rdata = {31'd0, q.memtest};
      end else if (araddr == `ADR_MODE) begin
        n.rdata = {30'd0, q.mode};
      end else if (araddr == `ADR_PRE) begin
        n.rdata = q.pre_cnt;
      end else if (araddr == `ADR_POST) begin
        n.rdata = q.post_cnt;
      end else if (araddr == `ADR_MEMSIZE) begin
        n.rdata = q.memsize;
      end else if (araddr == `ADR_TIMEOUT) begin
        n.rdata = q.tmo_ms;
      end else if (araddr == `ADR_BTYPE) begin
        n.rdata = q.s_type;
      end else if (araddr == `ADR_BDIR) begin
        n.rdata = q.s_dir;
      end else if (araddr == `ADR_NOTIFY) begin
        n.rdata = q.s_notify;
      end else if (araddr == `ADR_OFFSET) begin
        n.rdata = q.s_offs;
      end else if (araddr == `ADR_LENGTH) begin
        n.rdata = q.s_len;
      end else if (araddr == `ADR_BUFCTL) begin
        n.rdata = {29'd0, q.valid};      // Valid slot per buffer type
      end else begin
        n.rresp = `RESP_SLVERR;
      end
    end else if (q.rvalid && rready) begin
      n.rvalid = 1'b0;
    end

    // Ready flags and output mirrors, all registered
    n.awready     = !n.aw_got && !n.bvalid;
    n.wready      = !n.w_got && !n.bvalid;
    n.arready     = !n.rvalid;
    n.run_active  = n.rstate != acq_pkg::R_IDLE;
    n.xfer_active = n.xstate == acq_pkg::X_RUN;
  end

  // ****************************************
  // State register, synchronous reset
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q        <= '0;
      q.rstate <= acq_pkg::R_IDLE;
      q.xstate <= acq_pkg::X_IDLE;
    end else begin
      q <= n;
    end
  end

  // ****************************************
  // Outputs straight from the state register
  // ****************************************
  assign awready            = q.awready;
  assign wready             = q.wready;
  assign bvalid             = q.bvalid;
  assign bresp              = q.bresp;
  assign arready            = q.arready;
  assign rvalid             = q.rvalid;
  assign rdata              = q.rdata;
  assign rresp              = q.rresp;
  assign run_active         = q.run_active;
  assign trig_armed         = q.trig_en;
  assign xfer_active        = q.xfer_active;
  assign xfer_dir           = q.b_dir;
  assign xfer_addr          = q.addr;
  assign wait_busy          = q.wait_busy;
  assign notify_evt         = q.notify_evt;
  assign memory_test_enable = q.memtest;

endmodule

// ---- test/acq_checker.sv ----
// Purpose: Port checker for the run and transfer control block
// Assumes: Bound to the top module, one clock domain
// Notes:   Bus holds, transfer address steps and memory test lock
module acq_checker (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        awvalid, awready, wvalid, wready, bvalid, bready,
  input wire logic        arready, rvalid, rready,
  input wire logic [1:0]  bresp,
  input wire logic [31:0] rdata,
  // Block status
  input wire logic        run_active, xfer_active, xfer_beat, notify_evt,
  input wire logic        memory_test_enable,
  input wire logic [31:0] xfer_addr
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Answers stand until the master takes them
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  AST_W_ANSWER: assert property (awvalid && awready && wvalid && wready |=> bvalid)
    else $error("write not answered");
  AST_AW_BLOCK: assert property (bvalid |-> !awready && !wready)
    else $error("second write taken early");
  AST_AR_BLOCK: assert property (rvalid |-> !arready)
    else $error("second read taken early");
  // Each word moved advances the board address by four bytes
  AST_ADDR_STEP: assert property (xfer_active && xfer_beat |=>
    !xfer_active || xfer_addr == $past(xfer_addr) + 32'h0000_0004)
    else $error("board address step wrong");
  // Notification only follows a moved word, as a single pulse
  AST_NOTIFY_CAUSE: assert property (notify_evt |-> $past(xfer_beat) ##1 !notify_evt)
    else $error("notify without beat");
  // Memory test keeps the sequencer from starting
  AST_MT_LOCK: assert property (memory_test_enable && !run_active |=> !run_active)
    else $error("run started in memory test");
  cover property (notify_evt);
  cover property ($fell(xfer_active));
  cover property ($fell(run_active));
endmodule

// ---- test/acq_frontend_model.sv ----
// Purpose: Sample source and memory mover beside the block
// Assumes: One word moves per beat, only while a transfer runs
// Notes:   GAP idle cycles between ticks makes the mover slow or prompt
module acq_frontend_model #(
  parameter int GAP = 1  // Idle cycles between ticks
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic xfer_active,
  output logic     sample_tick,
  output logic     xfer_beat
);
  logic [3:0] cnt_q;  // Spacing counter
  // Free running spacing, cleared by reset
  always_ff @(posedge aclk) begin
    if (!aresetn || cnt_q >= GAP[3:0]) cnt_q <= 4'h0;
    else cnt_q <= cnt_q + 4'h1;
  end
  assign sample_tick = aresetn && cnt_q == 4'h0;
  // Whole words only, never outside a running transfer
  assign xfer_beat = xfer_active && cnt_q == 4'h0;
endmodule

// ---- test/acq_run_and_transfer_control_tb.sv ----
// Purpose: Self-checking bench for run and transfer control
// Assumes: Bus master holds bready and rready high throughout
// Notes:   MS_CYCLES shortened to keep the run brief
`include "acq_consts.svh"
module acq_run_and_transfer_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, trigger_in;
  logic awready, wready, bvalid, arready, rvalid, sample_tick, xfer_beat;
  logic run_active, trig_armed, xfer_active, xfer_dir, wait_busy, notify_evt;
  logic memory_test_enable, xfer_fail, fifo_flow_err;
  logic [19:0] awaddr, araddr;
  logic [31:0] wdata, rdata, xfer_addr;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  int miscompares, check_count;
  localparam logic [19:0] CMD = `IDX_CMD << 2;
  localparam logic [19:0] STS = `IDX_STATUS << 2;
  localparam logic [19:0] MT = `IDX_MEMTEST << 2;
  acq_run_and_transfer_control #(.MS_CYCLES(10)) uut (.awprot(3'h0), .arprot(3'h0), .*);
  acq_frontend_model #(.GAP(1)) fe (.*);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Address and data offered together, each released when taken
  // Always waits for a fresh edge: a back-to-back call must not see the last answer
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
    end while (!(bvalid && bready) && n < 40);
    r = bresp;
    if (!(bvalid && bready)) miscompares++;
  endtask
  task automatic rd(input logic [19:0] a, output logic [31:0] d);
    int n;
    n = 0;
    arvalid <= 1'b1; araddr <= a;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
    end while (!(rvalid && rready) && n < 40);
    d = rdata; r = rresp;
    if (!(rvalid && rready)) miscompares++;
  endtask
  task automatic rchk(input logic [19:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  task automatic poll(input logic [31:0] m);
    logic [31:0] d;
    d = 32'h0;
    for (int n = 0; n < 200 && (d & m) != m; n++) rd(STS, d);
  endtask
  task automatic def_buf(input logic [31:0] t, dir, nfy, len, offs);
    wr(`ADR_BTYPE, t); wr(`ADR_BDIR, dir); wr(`ADR_NOTIFY, nfy);
    wr(`ADR_OFFSET, offs); wr(`ADR_LENGTH, len); wr(`ADR_BUFCTL, 32'h0000_0001);
  endtask
  task automatic s_acq();
    wr(`ADR_MODE, 32'h0); wr(`ADR_PRE, 32'h2); wr(`ADR_POST, 32'h3);
    wr(`ADR_MEMSIZE, 32'h0000_0100); wr(CMD, 32'h0000_000c);
    chk(trig_armed, 1'b1);
    poll(32'h1); rchk(STS, 32'h0000_0001);
    trigger_in <= 1'b1;
    poll(32'h4); rchk(STS, 32'h0000_0007);
    trigger_in <= 1'b0;
  endtask
  task automatic s_xfer();
    def_buf(`BUF_SAMPLE, `DIR_B2H, 32'h0, 32'h10, 32'h10);
    rchk(`ADR_BUFCTL, 32'h1); wr(CMD, 32'h0003_0000);
    chk(xfer_dir, 1'b1); chk(wait_busy, 1'b1);
    poll(32'h200); chk(xfer_addr, 32'h20);
    // A fault while idle must not raise the error bit
    xfer_fail <= 1'b1;
    @(posedge aclk);
    xfer_fail <= 1'b0;
    rchk(STS, 32'h0000_0207); rchk(`ADR_BUFCTL, 32'h0); chk(wait_busy, 1'b0);
    def_buf(`BUF_SAMPLE, `DIR_B2H, 32'h10, 32'h20, 32'h0);
    wr(CMD, 32'h0001_0000);
    // Overrun while data moves is flagged and sticks
    fifo_flow_err <= 1'b1;
    @(posedge aclk);
    fifo_flow_err <= 1'b0;
    for (int n = 0; n < 100 && xfer_active; n++) @(posedge aclk);
    rchk(STS, 32'h0000_0507); chk(xfer_addr, 32'h20);
  endtask
  task automatic s_memtest();
    // Generation: armed at once, trigger ignored until enabled
    wr(`ADR_MODE, 32'h1); wr(CMD, 32'h0000_0004); rchk(STS, 32'h0000_0500);
    trigger_in <= 1'b1;
    rchk(STS, 32'h0000_0500); chk(run_active, 1'b1);
    wr(CMD, 32'h0000_0008); poll(32'h4); rchk(STS, 32'h0000_0506);
    trigger_in <= 1'b0;
    wr(`ADR_MODE, 32'h0);
    wr(MT, 32'h1); rchk(MT, 32'h1); wr(CMD, 32'h0000_000c);
    chk(run_active, 1'b0); rchk(STS, 32'h0000_0506);
    def_buf(`BUF_SAMPLE, `DIR_H2B, 32'h0, 32'h10, 32'h0);
    rchk(`ADR_BUFCTL, 32'h1); chk(xfer_dir, 1'b0);
    wr(MT, 32'h0); chk(memory_test_enable, 1'b0);
  endtask
  task automatic s_refuse();
    logic [31:0] t[3];
    t = '{`BUF_SAMPLE, `BUF_SLOW, `BUF_STAMP};
    for (int i = 0; i < 3; i++) begin
      def_buf(t[i], `DIR_B2H, 32'h0, 32'h10, 32'h0);
      rchk(`ADR_BUFCTL, 32'h1 << i);
    end
    wr(`ADR_BUFCTL, 32'h2); rchk(`ADR_BUFCTL, 32'h0);
    rchk(20'h0_0ff0, 32'h0); chk(r, `RESP_SLVERR); wr(STS, 32'h0); chk(r, `RESP_SLVERR);
    def_buf(`BUF_SAMPLE, `DIR_H2B, 32'h0, 32'h10, 32'h0);
    rchk(STS, 32'h0000_0d06);
    wr(`ADR_PRE, 32'h40); wr(CMD, 32'h4); rchk(STS, 32'h0000_0d00);
    chk(trig_armed, 1'b0); chk(run_active, 1'b1);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #200us;
    miscompares++;
    report_and_stop();
  end
  initial begin
    {aresetn, awvalid, wvalid, arvalid, trigger_in, xfer_fail, fifo_flow_err} = 7'h00;
    {bready, rready, wstrb} = 6'h3f;
    {awaddr, araddr, wdata} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    s_acq(); s_xfer(); s_memtest(); s_refuse();
    report_and_stop();
  end
endmodule
bind acq_run_and_transfer_control acq_checker chk_i (.*);
